// ---- inc/addr_gen_cfg.svh ----
`ifndef ADDR_GEN_CFG_SVH
`define ADDR_GEN_CFG_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define OFS_CONTROL 4'h0
`define OFS_X_START 4'h1
`define OFS_X_END 4'h2
`define OFS_Y_START 4'h3
`define OFS_Y_END 4'h4
`define OFS_REVERSAL 4'h5
`define OFS_STATUS 4'h6

// ----------------------------------------
// field positions and reset values
// ----------------------------------------
`define CTL_X_SEL_LSB 0
`define CTL_Y_SEL_LSB 4
`define CTL_REV_SEL_LSB 8
`define CTL_Y_EN_BIT 14
`define CTL_X_EN_BIT 15
`define CTL_WR_MASK 16'hCFFF
`define CTL_RST 16'h0FFF
`define REV_EN_BIT 15
`define SEL_OFF 4'hF
`define BOUND_RST 16'h0000
`define STAT_X_WRAP 0
`define STAT_Y_WRAP 1
`define STAT_MAC_ERR 2
`define STAT_CFG_ERR 3
`define MAX_LEN 17'h1_0000

`endif

// ---- inc/addr_gen_pkg.sv ----
package addr_gen_pkg;

    typedef enum logic [2:0] {
        AM_INDIRECT,
        AM_POST_INC,
        AM_POST_DEC,
        AM_PRE_INC,
        AM_PRE_DEC,
        AM_REG_OFFSET,
        AM_LIT_OFFSET
    } addr_mode_e;

    typedef enum logic [1:0] {
        LIT_NONE,
        LIT_BRANCH,
        LIT_DISABLE_COUNT
    } lit_kind_e;

endpackage : addr_gen_pkg

// ---- logic/modulo_address_generator.sv ----
`timescale 1ns/1ps
`include "addr_gen_cfg.svh"
// Contract
// - indexed base-plus-register mode for move instructions
// - one shared offset register field, both operands
// - dual-operand pointers limited to 8..11
// - pointers 8,9 to X; 10,11 to Y
// - dual-operand: indirect, post-modify 2/4/6, indexed
// - branch 16-bit signed, disable 14-bit count
// - one circular buffer each in X, Y
// - non-power-of-two buffers check one direction
// - power-of-two buffers check both boundaries
// - four 16-bit start and end registers
// - Y circular addresses keep LSB zero
// - length is end minus start plus one, max 32K words
// - X select bits 3:0, enable bit 15
// - Y select bits 7:4, enable bit 14
// - correction applies to any selected pointer
// - boundary test is beyond, not equal
// - write back only pre/post modify modes
// - reversed carry on X writes only
// - only modifier is bit-reversed
// - reversal needs select, enable, increment mode
// - reversal beats circular on X writes only
module modulo_address_generator (
    input wire logic clk,
    input wire logic rst,
    input wire logic [3:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_we,
    input wire logic reg_re,
    output logic [15:0] reg_rdata,
    input wire logic agu_req,
    input wire addr_gen_pkg::addr_mode_e agu_mode,
    input wire logic agu_write,
    input wire logic agu_byte,
    input wire logic agu_space_y,
    input wire logic agu_mac,
    input wire logic [2:0] agu_mac_step,
    input wire logic [3:0] agu_ptr_idx,
    input wire logic [15:0] agu_ptr_val,
    input wire logic [15:0] agu_offset_val,
    input wire logic [15:0] agu_literal,
    input wire addr_gen_pkg::lit_kind_e lit_kind,
    input wire logic [15:0] instr_literal,
    output logic ea_valid,
    output logic [15:0] ea_addr,
    output logic ea_space_y,
    output logic ea_error,
    output logic wb_en,
    output logic [3:0] wb_idx,
    output logic [15:0] wb_val,
    output logic [15:0] lit_value
);

    // ----------------------------------------
    // functions
    // ----------------------------------------
    function automatic logic [15:0] rev16(input logic [15:0] v);
        logic [15:0] r;
        r = '0;
        for (int i = 0; i < 16; i++)
        begin
            r[i] = v[15 - i];
        end
        return r;
    endfunction : rev16

    // returns {wrapped, address}; len is end - start + 1 in bytes
    function automatic logic [16:0] circ_fix(
        input logic [15:0] a,
        input logic [15:0] s,
        input logic [15:0] e,
        input logic up,
        input logic down
    );
        logic [16:0] len;
        logic pow2;
        logic [16:0] res;
        len = {1'b0, e} - {1'b0, s} + 17'h0_0001;
        pow2 = ((len & (len - 17'h0_0001)) == 17'h0_0000);
        res = {1'b0, a};
        if ((up || pow2) && (a > e))
        begin
            res = {1'b1, a - len[15:0]};
        end
        else if ((down || pow2) && (a < s))
        begin
            res = {1'b1, a + len[15:0]};
        end
        return res;
    endfunction : circ_fix

    // ----------------------------------------
    // registers
    // ----------------------------------------
    logic [15:0] ctl_q;
    logic [15:0] x_start_q;
    logic [15:0] x_end_q;
    logic [15:0] y_start_q;
    logic [15:0] y_end_q;
    logic [15:0] rev_q;
    logic [3:0] stat_q;
    logic [3:0] stat_d;

    wire logic [3:0] x_sel = ctl_q[`CTL_X_SEL_LSB +: 4];
    wire logic [3:0] y_sel = ctl_q[`CTL_Y_SEL_LSB +: 4];
    wire logic [3:0] rev_sel = ctl_q[`CTL_REV_SEL_LSB +: 4];
    wire logic x_on = ctl_q[`CTL_X_EN_BIT] && (x_sel != `SEL_OFF);
    wire logic y_on = ctl_q[`CTL_Y_EN_BIT] && (y_sel != `SEL_OFF);
    wire logic rev_on = rev_q[`REV_EN_BIT] && (rev_sel != `SEL_OFF);

    wire logic wr_ctl = reg_we && (reg_addr == `OFS_CONTROL);
    wire logic wr_xs = reg_we && (reg_addr == `OFS_X_START);
    wire logic wr_xe = reg_we && (reg_addr == `OFS_X_END);
    wire logic wr_ys = reg_we && (reg_addr == `OFS_Y_START);
    wire logic wr_ye = reg_we && (reg_addr == `OFS_Y_END);
    wire logic wr_rev = reg_we && (reg_addr == `OFS_REVERSAL);
    wire logic wr_stat = reg_we && (reg_addr == `OFS_STATUS);

    logic [15:0] rd_mux;
    always_comb
    begin
        case (reg_addr)
            `OFS_CONTROL: rd_mux = ctl_q;
            `OFS_X_START: rd_mux = x_start_q;
            `OFS_X_END: rd_mux = x_end_q;
            `OFS_Y_START: rd_mux = y_start_q;
            `OFS_Y_END: rd_mux = y_end_q;
            `OFS_REVERSAL: rd_mux = rev_q;
            `OFS_STATUS: rd_mux = {12'h000, stat_q};
            default: rd_mux = 16'h0000;
        endcase
    end

    // ----------------------------------------
    // request decode
    // ----------------------------------------
    wire logic m_post_inc = (agu_mode == addr_gen_pkg::AM_POST_INC);
    wire logic m_post_dec = (agu_mode == addr_gen_pkg::AM_POST_DEC);
    wire logic m_pre_inc = (agu_mode == addr_gen_pkg::AM_PRE_INC);
    wire logic m_pre_dec = (agu_mode == addr_gen_pkg::AM_PRE_DEC);
    wire logic m_reg_ofs = (agu_mode == addr_gen_pkg::AM_REG_OFFSET);
    wire logic m_lit_ofs = (agu_mode == addr_gen_pkg::AM_LIT_OFFSET);
    wire logic m_ind = (agu_mode == addr_gen_pkg::AM_INDIRECT);
    wire logic m_post = m_post_inc || m_post_dec;
    wire logic m_pre = m_pre_inc || m_pre_dec;

    // dual-operand checks: pointer set, modes and step sizes
    wire logic mac_ptr_ok = (agu_ptr_idx[3:2] == 2'b10);
    wire logic mac_step_ok = (agu_mac_step == 3'd2) || (agu_mac_step == 3'd4)
        || (agu_mac_step == 3'd6);
    wire logic mac_idx_ok = agu_ptr_idx[0]; // indexed only on pointers 9 and 11
    wire logic mac_mode_ok = m_ind || (m_post && mac_step_ok)
        || (m_reg_ofs && mac_idx_ok);
    wire logic mac_err = agu_mac && !(mac_ptr_ok && mac_mode_ok);

    // dual-operand reads route by pointer number, others by request
    wire logic space_y = agu_mac ? agu_ptr_idx[1] : agu_space_y;

    wire logic [15:0] step = agu_mac ? {13'h0000, agu_mac_step}
        : (agu_byte ? 16'h0001 : 16'h0002);

    // indexed mode takes the one shared offset register value
    logic [15:0] raw_new;
    always_comb
    begin
        if (m_post_inc || m_pre_inc)
        begin
            raw_new = agu_ptr_val + step;
        end
        else if (m_post_dec || m_pre_dec)
        begin
            raw_new = agu_ptr_val - step;
        end
        else if (m_reg_ofs)
        begin
            raw_new = agu_ptr_val + agu_offset_val;
        end
        else if (m_lit_ofs)
        begin
            raw_new = agu_ptr_val + agu_literal;
        end
        else
        begin
            raw_new = agu_ptr_val;
        end
    end

    // direction of travel; offsets use the sign of the offset
    wire logic go_down = m_post_dec || m_pre_dec
        || (m_reg_ofs && agu_offset_val[15]) || (m_lit_ofs && agu_literal[15]);
    wire logic go_up = !go_down && !m_ind;

    // ----------------------------------------
    // circular and reversed-carry paths
    // ----------------------------------------
    wire logic x_hit = x_on && !space_y && (agu_ptr_idx == x_sel) && !m_ind;
    wire logic y_hit = y_on && space_y && (agu_ptr_idx == y_sel) && !m_ind;
    wire logic rev_hit = rev_on && agu_write && !space_y && !agu_byte && !agu_mac
        && (m_pre_inc || m_post_inc) && (agu_ptr_idx == rev_sel);
    wire logic x_apply = x_hit && !rev_hit;

    wire logic [16:0] x_fix = circ_fix(raw_new, x_start_q, x_end_q, go_up, go_down);
    wire logic [16:0] y_fix = circ_fix(raw_new, y_start_q, y_end_q, go_up, go_down);

    // modifier is word scaled; carry runs from the top bit downward
    wire logic [15:0] rev_mod = {rev_q[14:0], 1'b0};
    wire logic [15:0] rev_sum = rev16(rev16(agu_ptr_val) + rev16(rev_mod));
    // the incoming pointer keeps normal bit order, only its LSB is dropped
    wire logic [15:0] rev_ptr = {agu_ptr_val[15:1], 1'b0};

    logic [15:0] new_addr;
    always_comb
    begin
        if (rev_hit)
        begin
            new_addr = {rev_sum[15:1], 1'b0};
        end
        else if (x_apply)
        begin
            new_addr = x_fix[15:0];
        end
        else if (y_hit)
        begin
            new_addr = {y_fix[15:1], 1'b0};
        end
        else
        begin
            new_addr = raw_new;
        end
    end

    // post modes and plain indirect use the pointer as it stands; reversed post-increment drops its LSB
    logic [15:0] ea_d;
    always_comb
    begin
        if (rev_hit && m_post_inc)
        begin
            ea_d = rev_ptr;
        end
        else if (m_post || m_ind)
        begin
            ea_d = agu_ptr_val;
        end
        else
        begin
            ea_d = new_addr;
        end
    end

    wire logic wb_d = agu_req && !mac_err && (m_pre || m_post);

    // ----------------------------------------
    // configuration and event flags
    // ----------------------------------------
    wire logic [16:0] x_len = {1'b0, x_end_q} - {1'b0, x_start_q} + 17'h0_0001;
    wire logic [16:0] y_len = {1'b0, y_end_q} - {1'b0, y_start_q} + 17'h0_0001;
    // end below start raises the configuration error flag; end one below start wraps the length to zero
    wire logic x_bad = (x_end_q < x_start_q) || (x_len > `MAX_LEN);
    wire logic y_bad = (y_end_q < y_start_q) || (y_len > `MAX_LEN);
    wire logic cfg_bad = (x_on && x_bad) || (y_on && y_bad);

    wire logic [3:0] stat_set = {
        cfg_bad,
        agu_req && mac_err,
        agu_req && y_hit && y_fix[16],
        agu_req && x_apply && x_fix[16]
    };
    // a flag raised in the clearing cycle survives the write of one
    always_comb
    begin
        stat_d = stat_q;
        if (wr_stat)
        begin
            stat_d = stat_q & ~reg_wdata[3:0];
        end
        stat_d = stat_d | stat_set;
    end

    // literals: branch displacement signed, disable count unsigned
    logic [15:0] lit_d;
    always_comb
    begin
        case (lit_kind)
            addr_gen_pkg::LIT_BRANCH: lit_d = instr_literal;
            addr_gen_pkg::LIT_DISABLE_COUNT: lit_d = {2'b00, instr_literal[13:0]};
            default: lit_d = lit_value;
        endcase
    end

    // ----------------------------------------
    // register file
    // ----------------------------------------
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            ctl_q <= `CTL_RST;
            rev_q <= 16'h0000;
            stat_q <= 4'h0;
        end
        else
        begin
            if (wr_ctl)
            begin
                ctl_q <= reg_wdata & `CTL_WR_MASK;
            end
            if (wr_rev)
            begin
                rev_q <= reg_wdata;
            end
            stat_q <= stat_d;
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            x_start_q <= `BOUND_RST;
            x_end_q <= `BOUND_RST;
            y_start_q <= `BOUND_RST;
            y_end_q <= `BOUND_RST;
        end
        else
        begin
            if (wr_xs)
            begin
                x_start_q <= reg_wdata;
            end
            if (wr_xe)
            begin
                x_end_q <= reg_wdata;
            end
            if (wr_ys)
            begin
                y_start_q <= {reg_wdata[15:1], 1'b0};
            end
            if (wr_ye)
            begin
                y_end_q <= {reg_wdata[15:1], 1'b1};
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            reg_rdata <= 16'h0000;
        end
        else
        begin
            reg_rdata <= reg_re ? rd_mux : 16'h0000;
        end
    end

    // ----------------------------------------
    // address outputs
    // ----------------------------------------
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            ea_valid <= 1'b0;
            ea_addr <= 16'h0000;
            ea_space_y <= 1'b0;
            ea_error <= 1'b0;
            wb_en <= 1'b0;
            wb_idx <= 4'h0;
            wb_val <= 16'h0000;
            lit_value <= 16'h0000;
        end
        else
        begin
            ea_valid <= agu_req;
            ea_error <= agu_req && mac_err;
            wb_en <= wb_d;
            lit_value <= lit_d;
            if (agu_req)
            begin
                ea_addr <= ea_d;
                ea_space_y <= space_y;
                wb_idx <= agu_ptr_idx;
                wb_val <= new_addr;
            end
        end
    end

endmodule : modulo_address_generator

// ---- verif/working_register_model.sv ----
`timescale 1ns/1ps
// ----------------------------------------
// pointer file and shared offset register
// ----------------------------------------
module working_register_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic load_en,
    input wire logic [3:0] load_idx,
    input wire logic [15:0] load_val,
    input wire logic [3:0] ptr_idx,
    input wire logic [3:0] offset_idx,
    input wire logic wb_en,
    input wire logic [3:0] wb_idx,
    input wire logic [15:0] wb_val,
    output logic [15:0] ptr_val,
    output logic [15:0] offset_val
);
    logic [15:0] regs_q [16];
    // a late write-back shows up only on the next request, as in the real file
    always_ff @(posedge clk)
    begin
        if (rst)
            for (int i = 0; i < 16; i++)
                regs_q[i] <= 16'h0000;
        else if (load_en)
            regs_q[load_idx] <= load_val;
        else if (wb_en)
            regs_q[wb_idx] <= wb_val;
    end
    assign ptr_val = regs_q[ptr_idx];
    assign offset_val = regs_q[offset_idx];
endmodule : working_register_model

// ---- verif/modulo_address_generator_sva.sv ----
`timescale 1ns/1ps
// ----------------------------------------
// port timing checks
// ----------------------------------------
module modulo_address_generator_sva (
    input wire logic clk,
    input wire logic rst,
    input wire logic reg_re,
    input wire logic [15:0] reg_rdata,
    input wire logic agu_req,
    input wire addr_gen_pkg::addr_mode_e agu_mode,
    input wire logic agu_mac,
    input wire logic [3:0] agu_ptr_idx,
    input wire addr_gen_pkg::lit_kind_e lit_kind,
    input wire logic [15:0] instr_literal,
    input wire logic ea_valid,
    input wire logic ea_space_y,
    input wire logic ea_error,
    input wire logic wb_en,
    input wire logic [3:0] wb_idx,
    input wire logic [15:0] lit_value
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    sequence s_req_wb;
        agu_req ##1 wb_en;
    endsequence
    sequence s_mac_req;
        agu_req && agu_mac;
    endsequence
    a_ea_timing: assert property (ea_valid == $past(agu_req))
        else $error("result pulse not one cycle after request");
    a_rd_idle: assert property (!reg_re |=> reg_rdata == 16'h0000)
        else $error("read data outside read cycle");
    a_mac_limit: assert property ((s_mac_req and (agu_ptr_idx[3:2] != 2'b10)) |=> ea_error)
        else $error("dual operand pointer outside 8..11 accepted");
    a_mac_space: assert property (s_mac_req |=> ea_space_y == $past(agu_ptr_idx[1]))
        else $error("dual operand routed to wrong space");
    a_err_nowb: assert property (ea_error |-> ea_valid && !wb_en)
        else $error("refused request wrote back");
    a_offset_nowb: assert property (agu_req && agu_mode inside {addr_gen_pkg::AM_INDIRECT,
        addr_gen_pkg::AM_REG_OFFSET, addr_gen_pkg::AM_LIT_OFFSET} |=> !wb_en)
        else $error("write back in offset mode");
    a_wb_target: assert property (s_req_wb |-> wb_idx == $past(agu_ptr_idx))
        else $error("write back to wrong pointer");
    a_lit_count: assert property (lit_kind == addr_gen_pkg::LIT_DISABLE_COUNT
        |=> lit_value == {2'b00, $past(instr_literal[13:0])})
        else $error("count literal not 14 bit unsigned");
    a_lit_branch: assert property (lit_kind == addr_gen_pkg::LIT_BRANCH
        |=> lit_value == $past(instr_literal))
        else $error("branch literal altered");
endmodule : modulo_address_generator_sva
bind modulo_address_generator modulo_address_generator_sva chk_u (.clk(clk), .rst(rst),
    .reg_re(reg_re), .reg_rdata(reg_rdata), .agu_req(agu_req), .agu_mode(agu_mode),
    .agu_mac(agu_mac), .agu_ptr_idx(agu_ptr_idx), .lit_kind(lit_kind),
    .instr_literal(instr_literal), .ea_valid(ea_valid), .ea_space_y(ea_space_y),
    .ea_error(ea_error), .wb_en(wb_en), .wb_idx(wb_idx), .lit_value(lit_value));

// ---- verif/testbench.sv ----
`timescale 1ns/1ps
`include "addr_gen_cfg.svh"
module testbench;
    logic clk = 0, rst = 1, reg_we = 0, reg_re = 0, agu_req = 0, agu_mac = 0, load_en = 0;
    logic [3:0] reg_addr = 0, agu_ptr_idx = 0, offset_idx = 0, load_idx = 0, wb_idx;
    logic [15:0] reg_wdata = 0, agu_literal = 0, instr_literal = 0, load_val = 0;
    logic [15:0] reg_rdata, ea_addr, wb_val, lit_value, ptr_val, offset_val, a;
    logic [2:0] agu_mac_step = 0;
    logic agu_write = 0, agu_byte = 0, agu_space_y = 0;
    logic ea_valid, ea_space_y, ea_error, wb_en, rd_due = 0;
    addr_gen_pkg::addr_mode_e agu_mode = addr_gen_pkg::AM_INDIRECT;
    addr_gen_pkg::lit_kind_e lit_kind = addr_gen_pkg::LIT_NONE;
    int failures = 0, n_checks = 0, seed = 20, cycles = 0;
    logic [15:0] rd_q[$];
    logic [36:0] ea_q[$];
    modulo_address_generator dut_u (.clk(clk), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata),
        .agu_req(agu_req), .agu_mode(agu_mode), .agu_write(agu_write), .agu_byte(agu_byte),
        .agu_space_y(agu_space_y), .agu_mac(agu_mac), .agu_mac_step(agu_mac_step),
        .agu_ptr_idx(agu_ptr_idx), .agu_ptr_val(ptr_val), .agu_offset_val(offset_val),
        .agu_literal(agu_literal), .lit_kind(lit_kind), .instr_literal(instr_literal),
        .ea_valid(ea_valid), .ea_addr(ea_addr), .ea_space_y(ea_space_y),
        .ea_error(ea_error), .wb_en(wb_en), .wb_idx(wb_idx), .wb_val(wb_val),
        .lit_value(lit_value));
    working_register_model regs_u (.clk(clk), .rst(rst), .load_en(load_en),
        .load_idx(load_idx), .load_val(load_val), .ptr_idx(agu_ptr_idx),
        .offset_idx(offset_idx), .wb_en(wb_en), .wb_idx(wb_idx), .wb_val(wb_val),
        .ptr_val(ptr_val), .offset_val(offset_val));
    always #50 clk = ~clk;
    task conclude();
        // a result that never showed up is a mismatch too
        if (ea_q.size() != 0 || rd_q.size() != 0)
            failures++;
        if (failures == 0 && n_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : conclude
    // hang guard, well above the roughly 120 cycles the sequence needs
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            failures++;
            conclude();
        end
    end
    task check(input logic [36:0] seen, input logic [36:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            failures++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check
    // ----------------------------------------
    // result watcher: bit 36 address compared, bit 35 write-back value compared
    // ----------------------------------------
    always @(negedge clk)
    begin
        logic [36:0] e;
        if (rd_due)
            check(reg_rdata, rd_q.pop_front());
        if (ea_valid === 1'b1)
        begin
            e = ea_q.pop_front();
            check({e[36:35], ea_error, ea_space_y, wb_en, e[36] ? ea_addr : e[31:16],
                e[35] ? wb_val : e[15:0]}, e);
        end
        rd_due = reg_re;
    end
    task wr(input logic [3:0] ad, input logic [15:0] d);
        @(posedge clk);
        reg_we <= 1'b1;
        reg_addr <= ad;
        reg_wdata <= d;
        @(posedge clk);
        reg_we <= 1'b0;
    endtask : wr
    task rd(input logic [3:0] ad, input logic [15:0] x);
        rd_q.push_back(x);
        @(posedge clk);
        reg_re <= 1'b1;
        reg_addr <= ad;
        @(posedge clk);
        reg_re <= 1'b0;
    endtask : rd
    task ld(input logic [3:0] i, input logic [15:0] v);
        @(posedge clk);
        load_en <= 1'b1;
        load_idx <= i;
        load_val <= v;
        @(posedge clk);
        load_en <= 1'b0;
    endtask : ld
    task req(input addr_gen_pkg::addr_mode_e m, input logic [3:0] p, input logic mac,
        input logic [2:0] st, input logic [36:0] x);
        ea_q.push_back(x);
        @(posedge clk);
        agu_req <= 1'b1;
        agu_mode <= m;
        agu_ptr_idx <= p;
        agu_mac <= mac;
        agu_mac_step <= st;
        @(posedge clk);
        agu_req <= 1'b0;
        @(posedge clk);
    endtask : req
    initial
    begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        rd(`OFS_CONTROL, 16'h0FFF);
        rd(`OFS_X_END, 16'h0000);
        rd(4'h7, 16'h0000);
        wr(`OFS_CONTROL, 16'h30F1);
        rd(`OFS_CONTROL, 16'h00F1);
        wr(`OFS_X_START, 16'h1000);
        wr(`OFS_X_END, 16'h100F);
        wr(`OFS_Y_START, 16'h2001);
        wr(`OFS_Y_END, 16'h2006);
        rd(`OFS_Y_START, 16'h2000);
        rd(`OFS_Y_END, 16'h2007);
        ld(1, 16'h100E);
        req(addr_gen_pkg::AM_POST_INC, 1, 0, 0, {5'b11001, 32'h100E_1010});
        wr(`OFS_CONTROL, 16'hC0A1);
        ld(1, 16'h100E);
        req(addr_gen_pkg::AM_POST_INC, 1, 0, 0, {5'b11001, 32'h100E_1000});
        req(addr_gen_pkg::AM_POST_INC, 1, 0, 0, {5'b11001, 32'h1000_1002});
        ld(1, 16'h1000);
        req(addr_gen_pkg::AM_PRE_DEC, 1, 0, 0, {5'b11001, 32'h100E_100E});
        ld(1, 16'h100C);
        agu_literal <= 16'h0006;
        req(addr_gen_pkg::AM_LIT_OFFSET, 1, 0, 0, {5'b10000, 32'h1002_0000});
        a = 16'($random(seed)) & 16'h0FFE;
        ld(4, a);
        ld(2, 16'h3000);
        offset_idx <= 4'h4;
        req(addr_gen_pkg::AM_REG_OFFSET, 2, 0, 0, {5'b10000, 16'h3000 + a, 16'h0});
        ld(10, 16'h2006);
        req(addr_gen_pkg::AM_POST_INC, 10, 1, 4, {5'b11011, 32'h2006_2002});
        ld(8, 16'h0800);
        a = 16'h0800;
        for (int k = 1; k <= 3; k++)
        begin
            req(addr_gen_pkg::AM_POST_INC, 8, 1, 3'(2 * k),
                {5'b11001, a, a + 16'(2 * k)});
            a = a + 16'(2 * k);
        end
        req(addr_gen_pkg::AM_POST_INC, 3, 1, 2, {5'b00110, 32'h0});
        // reversal and X circular on the same pointer
        wr(`OFS_CONTROL, 16'hC1A1);
        wr(`OFS_REVERSAL, 16'h8004);
        ld(1, 16'h1004);
        agu_write <= 1'b1;
        req(addr_gen_pkg::AM_POST_INC, 1, 0, 0, {5'b11001, 32'h1004_100C});
        agu_write <= 1'b0;
        req(addr_gen_pkg::AM_POST_INC, 1, 0, 0, {5'b11001, 32'h100C_100E});
        agu_write <= 1'b1;
        agu_byte <= 1'b1;
        req(addr_gen_pkg::AM_POST_INC, 1, 0, 0, {5'b11001, 32'h100E_100F});
        agu_byte <= 1'b0;
        agu_space_y <= 1'b1;
        req(addr_gen_pkg::AM_POST_DEC, 10, 0, 0, {5'b11011, 32'h2002_2000});
        req(addr_gen_pkg::AM_POST_DEC, 10, 0, 0, {5'b11011, 32'h2000_2006});
        agu_space_y <= 1'b0;
        agu_write <= 1'b0;
        // literal widths are judged by the checker alone
        @(posedge clk);
        lit_kind <= addr_gen_pkg::LIT_BRANCH;
        instr_literal <= 16'($random(seed));
        @(posedge clk);
        lit_kind <= addr_gen_pkg::LIT_DISABLE_COUNT;
        instr_literal <= 16'($random(seed));
        @(posedge clk);
        lit_kind <= addr_gen_pkg::LIT_NONE;
        repeat (3) @(posedge clk);
        rd(`OFS_STATUS, 16'h0007);
        wr(`OFS_STATUS, 16'h000F);
        rd(`OFS_STATUS, 16'h0000);
        wr(`OFS_X_END, 16'h0FFF);
        rd(`OFS_STATUS, 16'h0008);
        repeat (3) @(posedge clk);
        conclude();
    end
endmodule : testbench
